// *** rtl/wdcd_consts.vh ***
// constants shared by the common descriptor decoder files
// assumes inclusion by bare name from the rtl/ directory
`ifndef WDCD_CONSTS_VH
`define WDCD_CONSTS_VH

// descriptor geometry, in 8-byte words
`define WDCD_DESC_WORDS      4'd8
`define WDCD_LAST_WORD       3'd7
`define WDCD_WORD_IDENT      3'd0
`define WDCD_WORD_COMPL      3'd1
`define WDCD_WORD_SRC        3'd2
`define WDCD_WORD_DST        3'd3
`define WDCD_WORD_SIZE       3'd4

// descriptor word fields; identity word sits in bits 31:0 of word 0, size and handle in word 4
`define WDCD_PRIV_BIT        31
`define WDCD_SPACE_MSB       19
`define WDCD_SPACE_LSB       0
`define WDCD_OPCODE_MSB      63
`define WDCD_OPCODE_LSB      56
`define WDCD_SIZE_MSB        31
`define WDCD_SIZE_LSB        0
`define WDCD_HANDLE_MSB      63
`define WDCD_HANDLE_LSB      48

// operation codes
`define WDCD_OP_NOOP         8'h00
`define WDCD_OP_BATCH        8'h01
`define WDCD_OP_DRAIN        8'h02
`define WDCD_OP_MOVE         8'h03
`define WDCD_OP_FILL         8'h04
`define WDCD_OP_COMPARE      8'h05
`define WDCD_OP_CMP_PAT      8'h06
`define WDCD_OP_CR_DELTA     8'h07
`define WDCD_OP_AP_DELTA     8'h08
`define WDCD_OP_DUALCAST     8'h09
`define WDCD_OP_XLAT_FETCH   8'h0A
`define WDCD_OP_CRC_GEN      8'h10
`define WDCD_OP_COPY_CRC     8'h11
`define WDCD_OP_DIF_CHECK    8'h12
`define WDCD_OP_DIF_INSERT   8'h13
`define WDCD_OP_DIF_STRIP    8'h14
`define WDCD_OP_DIF_UPDATE   8'h15
`define WDCD_OP_DIX_GEN      8'h17
`define WDCD_OP_TYPE_CONV    8'h18
`define WDCD_OP_REDUCE       8'h19
`define WDCD_OP_REDUCE_DC    8'h1A
`define WDCD_OP_GATHER_RED   8'h1B
`define WDCD_OP_GATHER_CPY   8'h1C
`define WDCD_OP_SCATTER_CPY  8'h1D
`define WDCD_OP_SCATTER_FIL  8'h1E
`define WDCD_OP_CACHE_FLUSH  8'h20
`define WDCD_OP_WIN_UPDATE   8'h21
`define WDCD_OP_ID_COPY      8'h23
`define WDCD_OP_ID_FILL      8'h24
`define WDCD_OP_ID_COMPARE   8'h25
`define WDCD_OP_ID_CMP_PAT   8'h26

// operation classes, one-hot apart from none, which is zero
`define WDCD_CLS_NONE        4'h0
`define WDCD_CLS_CONTROL     4'h1
`define WDCD_CLS_DATA        4'h2
`define WDCD_CLS_INTEGRITY   4'h4
`define WDCD_CLS_GATHER      4'h8

// completion status codes
`define WDCD_STATUS_OK       8'h00
`define WDCD_STATUS_UNSUPP   8'h10

// register byte offsets
`define WDCD_REG_CTRL        8'h00
`define WDCD_REG_STATUS      8'h04
`define WDCD_REG_ACCEPT_CNT  8'h08
`define WDCD_REG_UNSUPP_CNT  8'h0C
`define WDCD_REG_LENERR_CNT  8'h10
`define WDCD_REG_LAST_IDENT  8'h14
`define WDCD_REG_LAST_OP     8'h18
`define WDCD_REG_QCFG_BASE   8'h20

// register fields and reset values
`define WDCD_CTRL_EN_BIT     0
`define WDCD_CTRL_CLR_BIT    1
`define WDCD_CTRL_RESET      32'h0000_0001
`define WDCD_QCFG_RESET      32'h0000_0000
`define WDCD_QCFG_MASK       32'h800F_FFFF

// axi responses
`define WDCD_RESP_OKAY       2'b00
`define WDCD_RESP_SLVERR     2'b10

`endif

// *** rtl/wdcd_opcode_decode.v ***
// operation code decoder for the common descriptor decoder
// assumes the code comes straight from the descriptor word; purely combinational
`timescale 1ns/10ps
`include "wdcd_consts.vh"

module wdcd_opcode_decode
(
   // code in
   input  wire [7:0] opcode_i,
   // decode out
   output reg        reserved_o,
   output reg        batch_o,
   output reg  [3:0] class_o
);

   always @*
   begin
      reserved_o = 1'b0;
      batch_o    = 1'b0;
      class_o    = `WDCD_CLS_NONE;
      case (opcode_i)
         `WDCD_OP_NOOP, `WDCD_OP_DRAIN, `WDCD_OP_XLAT_FETCH:
            class_o = `WDCD_CLS_CONTROL;
         `WDCD_OP_BATCH:
         begin
            class_o = `WDCD_CLS_CONTROL;
            batch_o = 1'b1;
         end
         `WDCD_OP_MOVE, `WDCD_OP_FILL, `WDCD_OP_COMPARE, `WDCD_OP_CMP_PAT,
         `WDCD_OP_CR_DELTA, `WDCD_OP_AP_DELTA, `WDCD_OP_DUALCAST:
            class_o = `WDCD_CLS_DATA;
         `WDCD_OP_CRC_GEN, `WDCD_OP_COPY_CRC, `WDCD_OP_DIF_CHECK,
         `WDCD_OP_DIF_INSERT, `WDCD_OP_DIF_STRIP, `WDCD_OP_DIF_UPDATE,
         `WDCD_OP_DIX_GEN:
            class_o = `WDCD_CLS_INTEGRITY;
         `WDCD_OP_TYPE_CONV, `WDCD_OP_REDUCE, `WDCD_OP_REDUCE_DC,
         `WDCD_OP_GATHER_RED, `WDCD_OP_GATHER_CPY, `WDCD_OP_SCATTER_CPY,
         `WDCD_OP_SCATTER_FIL:
            class_o = `WDCD_CLS_GATHER;
         `WDCD_OP_CACHE_FLUSH, `WDCD_OP_WIN_UPDATE:
            class_o = `WDCD_CLS_CONTROL;
         `WDCD_OP_ID_COPY, `WDCD_OP_ID_FILL, `WDCD_OP_ID_COMPARE,
         `WDCD_OP_ID_CMP_PAT:
            class_o = `WDCD_CLS_DATA;
         default:
            reserved_o = 1'b1;
      endcase
   end

endmodule // wdcd_opcode_decode

// *** rtl/wdcd_identity_select.v ***
// picks the privilege and address space id that a descriptor runs under
// assumes all inputs are on the decoder clock and stable when read
`timescale 1ns/10ps
`include "wdcd_consts.vh"

module wdcd_identity_select
(
   // arrival context
   input  wire        shared_i,
   input  wire        in_batch_i,
   // identity word from the descriptor
   input  wire [31:0] ident_i,
   // queue configuration and enclosing batch
   input  wire [31:0] queue_cfg_i,
   input  wire        batch_priv_i,
   input  wire [19:0] batch_space_id_i,
   // resolved identity
   output reg         priv_o,
   output reg  [19:0] space_id_o
);

   // bits 30:20 of the identity word are never looked at
   always @*
   begin
      if (in_batch_i)
      begin
         priv_o     = batch_priv_i;
         space_id_o = batch_space_id_i;
      end
      else if (shared_i)
      begin
         // trusted as is: filled by the core or privileged software
         priv_o     = ident_i[`WDCD_PRIV_BIT];
         space_id_o = ident_i[`WDCD_SPACE_MSB:`WDCD_SPACE_LSB];
      end
      else
      begin
         priv_o     = queue_cfg_i[`WDCD_PRIV_BIT];
         space_id_o = queue_cfg_i[`WDCD_SPACE_MSB:`WDCD_SPACE_LSB];
      end
   end

endmodule // wdcd_identity_select

// *** rtl/wdcd_top.v ***
// common field decoder for 64-byte work descriptors, with axi4-lite registers
// assumes descriptor words come from logic on clock_i, eight 8-byte words each
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "wdcd_consts.vh"

module wdcd_top
#(
   parameter QUEUES = 2,
   parameter QIDX_W = 1,
   parameter ADDR_W = 8
)
(
   // clock and reset
   input  wire              clock_i,
   input  wire              sys_rst_i,
   // axi4-lite write
   input  wire [ADDR_W-1:0] s_axi_awaddr_i,
   input  wire              s_axi_awvalid_i,
   output wire              s_axi_awready_o,
   input  wire [31:0]       s_axi_wdata_i,
   input  wire [3:0]        s_axi_wstrb_i,
   input  wire              s_axi_wvalid_i,
   output wire              s_axi_wready_o,
   output wire [1:0]        s_axi_bresp_o,
   output wire              s_axi_bvalid_o,
   input  wire              s_axi_bready_i,
   // axi4-lite read
   input  wire [ADDR_W-1:0] s_axi_araddr_i,
   input  wire              s_axi_arvalid_i,
   output wire              s_axi_arready_o,
   output wire [31:0]       s_axi_rdata_o,
   output wire [1:0]        s_axi_rresp_o,
   output wire              s_axi_rvalid_o,
   input  wire              s_axi_rready_i,
   // descriptor words in
   input  wire              desc_valid_i,
   output wire              desc_ready_o,
   input  wire [63:0]       desc_word_i,
   input  wire              desc_last_i,
   input  wire              desc_shared_i,
   input  wire              desc_in_batch_i,
   input  wire [QIDX_W-1:0] desc_queue_i,
   // decoded descriptor out
   output wire              dec_valid_o,
   input  wire              dec_ready_i,
   output wire              dec_priv_o,
   output wire [19:0]       dec_space_id_o,
   output wire [7:0]        dec_opcode_o,
   output wire [3:0]        dec_class_o,
   output wire              dec_batch_o,
   output wire              dec_unsupported_o,
   output wire [7:0]        dec_status_o,
   output wire [63:0]       dec_compl_addr_o,
   output wire [63:0]       dec_src_addr_o,
   output wire [63:0]       dec_dst_addr_o,
   output wire [31:0]       dec_xfer_size_o,
   output wire [15:0]       dec_int_handle_o
);

   localparam [2:0] ST_COLLECT = 3'b001;
   localparam [2:0] ST_DRAIN   = 3'b010;
   localparam [2:0] ST_HOLD    = 3'b100;

   function [31:0] apply_strb;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  strb;
      integer      k;
      begin
         apply_strb = old_v;
         for (k = 0; k < 4; k = k + 1)
            if (strb[k])
               apply_strb[k*8 +: 8] = new_v[k*8 +: 8];
      end
   endfunction

   function qcfg_hit;
      input [ADDR_W-1:0] a;
      begin
         qcfg_hit = (a >= `WDCD_REG_QCFG_BASE) && (a[1:0] == 2'b00) &&
                    (((a - `WDCD_REG_QCFG_BASE) >> 2) < QUEUES);
      end
   endfunction

   function [QIDX_W-1:0] qcfg_idx;
      input [ADDR_W-1:0] a;
      reg   [ADDR_W-1:0] d;
      begin
         d        = (a - `WDCD_REG_QCFG_BASE) >> 2;
         qcfg_idx = d[QIDX_W-1:0];
      end
   endfunction

   // bus registers
   reg              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   reg              aw_hold_q, w_hold_q;
   reg [ADDR_W-1:0] aw_addr_q;
   reg [31:0]       w_data_q;
   reg [3:0]        w_strb_q;
   reg [1:0]        bresp_q, rresp_q;
   reg [31:0]       rdata_q;
   reg [31:0]       ctrl_q;
   reg [31:0]       qcfg_q [0:QUEUES-1];
   reg [31:0]       accept_cnt_q, unsupp_cnt_q, lenerr_cnt_q;
   integer          i;

   // descriptor path registers
   reg [2:0]        state_q;
   reg [2:0]        state_d;
   reg [2:0]        widx_q;
   reg              ready_q;
   reg              dvalid_q, dpriv_q, dbatch_q, dunsupp_q, dinb_q;
   reg [19:0]       dspace_q;
   reg [7:0]        dop_q, dstatus_q;
   reg [3:0]        dclass_q;
   reg [63:0]       dcompl_q, dsrc_q, ddst_q;
   reg [31:0]       dsize_q;
   reg [15:0]       dhandle_q;
   reg              batch_priv_q, batch_valid_q;
   reg [19:0]       batch_space_q;

   wire             do_write = aw_hold_q && w_hold_q && !bvalid_q;
   wire             wr_clr   = do_write && (aw_addr_q == `WDCD_REG_CTRL) &&
                               w_strb_q[0] && w_data_q[`WDCD_CTRL_CLR_BIT];
   wire             take     = desc_valid_i && ready_q;
   wire             at_last  = (widx_q == `WDCD_LAST_WORD);
   // a drained tail is not counted again: only collection can see a length error
   wire             len_bad  = take && (state_q == ST_COLLECT) &&
                               (desc_last_i != at_last);
   wire             finish   = take && desc_last_i && at_last && (state_q == ST_COLLECT);
   wire [31:0]      qcfg_sel = (desc_queue_i < QUEUES) ? qcfg_q[desc_queue_i] :
                               `WDCD_QCFG_RESET;

   wire             sel_priv;
   wire [19:0]      sel_space;
   wire             op_res, op_batch;
   wire [3:0]       op_class;
   wire [7:0]       op_code  = desc_word_i[`WDCD_OPCODE_MSB:`WDCD_OPCODE_LSB];

   wdcd_identity_select u_ident
   (
      .shared_i         (desc_shared_i),
      .in_batch_i       (desc_in_batch_i),
      .ident_i          (desc_word_i[31:0]),
      .queue_cfg_i      (qcfg_sel),
      .batch_priv_i     (batch_priv_q),
      .batch_space_id_i (batch_space_q),
      .priv_o           (sel_priv),
      .space_id_o       (sel_space)
   );

   wdcd_opcode_decode u_opdec
   (
      .opcode_i   (op_code),
      .reserved_o (op_res),
      .batch_o    (op_batch),
      .class_o    (op_class)
   );

   // axi write channel: address and data taken in either order
   always @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         aw_addr_q <= {ADDR_W{1'b0}};
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `WDCD_RESP_OKAY;
         ctrl_q    <= `WDCD_CTRL_RESET;
         for (i = 0; i < QUEUES; i = i + 1)
            qcfg_q[i] <= `WDCD_QCFG_RESET;
      end
      else
      begin
         if (s_axi_awvalid_i && awready_q)
         begin
            aw_hold_q <= 1'b1;
            awready_q <= 1'b0;
            aw_addr_q <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && wready_q)
         begin
            w_hold_q <= 1'b1;
            wready_q <= 1'b0;
            w_data_q <= s_axi_wdata_i;
            w_strb_q <= s_axi_wstrb_i;
         end
         if (do_write)
         begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= `WDCD_RESP_OKAY;
            if (aw_addr_q == `WDCD_REG_CTRL)
               ctrl_q <= apply_strb(ctrl_q, w_data_q, w_strb_q) &
                         32'h0000_0001;
            else if (qcfg_hit(aw_addr_q))
               qcfg_q[qcfg_idx(aw_addr_q)] <=
                  apply_strb(qcfg_q[qcfg_idx(aw_addr_q)], w_data_q, w_strb_q) &
                  `WDCD_QCFG_MASK;
            else if ((aw_addr_q != `WDCD_REG_STATUS) &&
                     (aw_addr_q != `WDCD_REG_ACCEPT_CNT) &&
                     (aw_addr_q != `WDCD_REG_UNSUPP_CNT) &&
                     (aw_addr_q != `WDCD_REG_LENERR_CNT) &&
                     (aw_addr_q != `WDCD_REG_LAST_IDENT) &&
                     (aw_addr_q != `WDCD_REG_LAST_OP))
               bresp_q <= `WDCD_RESP_SLVERR;
         end
         if (bvalid_q && s_axi_bready_i)
         begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // axi read channel
   always @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= `WDCD_RESP_OKAY;
      end
      else if (s_axi_arvalid_i && arready_q)
      begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rresp_q   <= `WDCD_RESP_OKAY;
         rdata_q   <= 32'h0000_0000;
         case (s_axi_araddr_i)
            `WDCD_REG_CTRL:       rdata_q <= ctrl_q;
            `WDCD_REG_STATUS:     rdata_q <= {15'h0000, batch_valid_q, 5'h00, widx_q,
                                              5'h00, state_q};
            `WDCD_REG_ACCEPT_CNT: rdata_q <= accept_cnt_q;
            `WDCD_REG_UNSUPP_CNT: rdata_q <= unsupp_cnt_q;
            `WDCD_REG_LENERR_CNT: rdata_q <= lenerr_cnt_q;
            `WDCD_REG_LAST_IDENT: rdata_q <= {dpriv_q, 11'h000, dspace_q};
            `WDCD_REG_LAST_OP:    rdata_q <= {16'h0000, dstatus_q, dop_q};
            default:
               if (qcfg_hit(s_axi_araddr_i))
                  rdata_q <= qcfg_q[qcfg_idx(s_axi_araddr_i)];
               else
                  rresp_q <= `WDCD_RESP_SLVERR;
         endcase
      end
      else if (rvalid_q && s_axi_rready_i)
      begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // counters; an event in the clearing cycle is kept
   always @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         accept_cnt_q <= 32'h0000_0000;
         unsupp_cnt_q <= 32'h0000_0000;
         lenerr_cnt_q <= 32'h0000_0000;
      end
      else if (wr_clr)
      begin
         accept_cnt_q <= {31'h0000_0000, finish};
         unsupp_cnt_q <= {31'h0000_0000, finish && dunsupp_q};
         lenerr_cnt_q <= {31'h0000_0000, len_bad};
      end
      else
      begin
         if (finish)
            accept_cnt_q <= accept_cnt_q + 32'h0000_0001;
         if (finish && dunsupp_q)
            unsupp_cnt_q <= unsupp_cnt_q + 32'h0000_0001;
         if (len_bad)
            lenerr_cnt_q <= lenerr_cnt_q + 32'h0000_0001;
      end
   end

   // word sequencer; a short or long descriptor is dropped whole
   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_COLLECT:
            if (finish)
               state_d = ST_HOLD;
            else if (take && at_last && !desc_last_i)
               state_d = ST_DRAIN;
         ST_DRAIN:
            if (take && desc_last_i)
               state_d = ST_COLLECT;
         ST_HOLD:
            if (dec_ready_i)
               state_d = ST_COLLECT;
         default:
            state_d = ST_COLLECT;
      endcase
   end

   always @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         state_q <= ST_COLLECT;
         widx_q  <= 3'd0;
         ready_q <= 1'b0;
         dvalid_q <= 1'b0;
      end
      else
      begin
         state_q  <= state_d;
         ready_q  <= (state_d != ST_HOLD) && ctrl_q[`WDCD_CTRL_EN_BIT];
         dvalid_q <= (state_d == ST_HOLD);
         if (take)
            widx_q <= (desc_last_i || state_q == ST_DRAIN && at_last) ? 3'd0 :
                      widx_q + 3'd1;
      end
   end

   // field capture; output fields are stable while the result is offered
   always @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         dpriv_q       <= 1'b0;
         dspace_q      <= 20'h0_0000;
         dop_q         <= 8'h00;
         dclass_q      <= `WDCD_CLS_NONE;
         dbatch_q      <= 1'b0;
         dunsupp_q     <= 1'b0;
         dstatus_q     <= `WDCD_STATUS_OK;
         dinb_q        <= 1'b0;
         dcompl_q      <= 64'h0000_0000_0000_0000;
         dsrc_q        <= 64'h0000_0000_0000_0000;
         ddst_q        <= 64'h0000_0000_0000_0000;
         dsize_q       <= 32'h0000_0000;
         dhandle_q     <= 16'h0000;
         batch_priv_q  <= 1'b0;
         batch_space_q <= 20'h0_0000;
         batch_valid_q <= 1'b0;
      end
      else
      begin
         if (take && state_q == ST_COLLECT)
            case (widx_q)
               `WDCD_WORD_IDENT:
               begin
                  dpriv_q   <= sel_priv;
                  dspace_q  <= sel_space;
                  dop_q     <= op_code;
                  dclass_q  <= op_class;
                  dbatch_q  <= op_batch && !op_res;
                  dunsupp_q <= op_res;
                  dstatus_q <= op_res ? `WDCD_STATUS_UNSUPP : `WDCD_STATUS_OK;
                  dinb_q    <= desc_in_batch_i;
               end
               `WDCD_WORD_COMPL: dcompl_q <= desc_word_i;
               `WDCD_WORD_SRC:   dsrc_q   <= desc_word_i;
               `WDCD_WORD_DST:   ddst_q   <= desc_word_i;
               `WDCD_WORD_SIZE:
               begin
                  dsize_q   <= desc_word_i[`WDCD_SIZE_MSB:`WDCD_SIZE_LSB];
                  dhandle_q <= desc_word_i[`WDCD_HANDLE_MSB:`WDCD_HANDLE_LSB];
               end
               default:
                  dinb_q <= dinb_q;
            endcase
         // a batch descriptor's identity governs the members that follow it
         if (finish && dbatch_q && !dinb_q)
         begin
            batch_priv_q  <= dpriv_q;
            batch_space_q <= dspace_q;
            batch_valid_q <= 1'b1;
         end
      end
   end

   assign s_axi_awready_o   = awready_q;
   assign s_axi_wready_o    = wready_q;
   assign s_axi_bresp_o     = bresp_q;
   assign s_axi_bvalid_o    = bvalid_q;
   assign s_axi_arready_o   = arready_q;
   assign s_axi_rdata_o     = rdata_q;
   assign s_axi_rresp_o     = rresp_q;
   assign s_axi_rvalid_o    = rvalid_q;
   assign desc_ready_o      = ready_q;
   assign dec_valid_o       = dvalid_q;
   assign dec_priv_o        = dpriv_q;
   assign dec_space_id_o    = dspace_q;
   assign dec_opcode_o      = dop_q;
   assign dec_class_o       = dclass_q;
   assign dec_batch_o       = dbatch_q;
   assign dec_unsupported_o = dunsupp_q;
   assign dec_status_o      = dstatus_q;
   assign dec_compl_addr_o  = dcompl_q;
   assign dec_src_addr_o    = dsrc_q;
   assign dec_dst_addr_o    = ddst_q;
   assign dec_xfer_size_o   = dsize_q;
   assign dec_int_handle_o  = dhandle_q;

endmodule // wdcd_top

// *** dv/wdcd_props.sv ***
// checker for the descriptor decoder output and axi write response holding
// assumes binding to wdcd_top; sees only its ports
`timescale 1ns/10ps
module wdcd_props
(
   // watched ports
   input wire       clock_i,
   input wire       sys_rst_i,
   input wire       dec_valid_o,
   input wire       dec_ready_i,
   input wire [7:0] dec_opcode_o,
   input wire       dec_unsupported_o,
   input wire [7:0] dec_status_o,
   input wire [3:0] dec_class_o,
   input wire       dec_batch_o,
   input wire       desc_ready_o,
   input wire       s_axi_bvalid_o,
   input wire       s_axi_bready_i
);
   wire [7:0] op = dec_opcode_o;
   wire rsv = (op > 8'h0A && op < 8'h10) || op == 8'h16 || op == 8'h1F || op == 8'h22 || op > 8'h26;
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   a_rsvd_code: assert property
      (dec_valid_o |-> dec_unsupported_o == rsv) else $error("reserved flag wrong");
   a_unsupp_status: assert property
      (dec_valid_o && rsv |-> dec_status_o == 8'h10 && dec_class_o == 4'h0) else $error("bad status");
   a_ok_status: assert property
      (dec_valid_o && !rsv |-> dec_status_o == 8'h00 && dec_class_o != 4'h0) else $error("bad class");
   a_batch_flag: assert property
      (dec_valid_o |-> dec_batch_o == (op == 8'h01)) else $error("batch flag wrong");
   a_out_hold: assert property
      (dec_valid_o && !dec_ready_i |=> dec_valid_o && $stable(op)) else $error("result dropped");
   a_out_drop: assert property
      (dec_valid_o && dec_ready_i |=> !dec_valid_o) else $error("result repeated");
   a_in_block: assert property
      (dec_valid_o |-> !desc_ready_o) else $error("words taken while result held");
   a_b_hold: assert property
      (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o) else $error("bvalid dropped");
endmodule // wdcd_props
bind wdcd_top wdcd_props i_props (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
   .dec_valid_o(dec_valid_o), .dec_ready_i(dec_ready_i), .dec_opcode_o(dec_opcode_o),
   .dec_unsupported_o(dec_unsupported_o), .dec_status_o(dec_status_o),
   .dec_class_o(dec_class_o), .dec_batch_o(dec_batch_o), .desc_ready_o(desc_ready_o),
   .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i));

// *** dv/wdcd_host_model.sv ***
// host side model sending 64-byte descriptors as eight words
// assumes send is called just after a rising clock edge
`timescale 1ns/10ps
module wdcd_host_model #(parameter [19:0] TSID = 20'h0_0A5C) // arbitrary thread id
(
   // word stream
   input  wire        clock_i,
   input  wire        ready_i,
   output reg         valid_o = 0,
   output reg  [63:0] word_o = 0,
   output reg         last_o = 0
);
   integer n;
   task send(input [511:0] d, input user);
      begin
         if (user) d[31:0] = {12'h000, TSID};
         for (n = 0; n < 8; n = n + 1)
         begin
            valid_o <= 1; word_o <= d[64*n +: 64]; last_o <= (n == 7);
            @(negedge clock_i);
            while (!ready_i) @(negedge clock_i);
            @(posedge clock_i);
         end
         // released lines show the inverse, not a stale word
         valid_o <= 0; word_o <= ~d[511:448]; last_o <= 0;
      end
   endtask
endmodule // wdcd_host_model

// *** dv/tb.sv ***
// self-checking bench for wdcd_top with random descriptors
// assumes the host model and checker files are compiled first
`timescale 1ns/10ps
module tb;
   reg clock_i = 0, sys_rst_i = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, dr = 0;
   reg sh = 1, ib = 0, q = 0;
   reg [7:0] aw = 0, ar = 0;
   reg [31:0] wd = 0, t;
   reg [511:0] d, e;
   wire awr, wrdy, bv, arr, rv, dv, dp, dun, drdy, dlast, dvld;
   wire [1:0] br, rr;
   wire [31:0] rdat, dsz;
   wire [63:0] dw, dca, dda, dsa;
   wire [15:0] dih;
   wire [19:0] dsid;
   wire [7:0] dop, dst;
   integer seed = 48478, bad_count = 0, samples_checked = 0, cyc = 0, i, j;
   always #10 clock_i = ~clock_i;
   always @(posedge clock_i) dr <= $random(seed);
   wdcd_host_model h (.clock_i(clock_i), .ready_i(drdy), .valid_o(dvld), .word_o(dw),
      .last_o(dlast));
   wdcd_top i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr_i(aw),
      .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
      .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(bre), .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre),
      .desc_valid_i(dvld), .desc_ready_o(drdy), .desc_word_i(dw), .desc_last_i(dlast),
      .desc_shared_i(sh), .desc_in_batch_i(ib), .desc_queue_i(q), .dec_valid_o(dv),
      .dec_ready_i(dr), .dec_priv_o(dp), .dec_space_id_o(dsid), .dec_opcode_o(dop),
      .dec_class_o(), .dec_batch_o(), .dec_unsupported_o(dun), .dec_status_o(dst),
      .dec_compl_addr_o(dca), .dec_src_addr_o(dsa), .dec_dst_addr_o(dda), .dec_xfer_size_o(dsz),
      .dec_int_handle_o(dih));
   function rsv(input [7:0] o);
      rsv = (o > 8'h0A && o < 8'h10) || o == 8'h16 || o == 8'h1F || o == 8'h22 || o > 8'h26;
   endfunction
   task ck(input ok);
      begin
         samples_checked = samples_checked + 1;
         if (!ok)
         begin
            bad_count = bad_count + 1;
            $display("FAIL %0t mismatch", $time);
         end
      end
   endtask
   task tally_and_finish;
      begin
         $display("checked %0d mismatches %0d", samples_checked, bad_count);
         if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task axw(input [7:0] a, input [31:0] v, input [1:0] er);
      reg ta, tw, tr;
      begin
         aw <= a; wd <= v; awv <= 1; wv <= 1; bre <= 1;
         forever
         begin
            @(negedge clock_i); ta = awv & awr; tw = wv & wrdy; tr = bv;
            @(posedge clock_i);
            if (ta) awv <= 0;
            if (tw) wv <= 0;
            if (tr)
            begin
               bre <= 0; ck(br === er); break;
            end
         end
      end
   endtask
   task axr(input [7:0] a, input [31:0] ev, input [1:0] er);
      reg ta, tr;
      begin
         ar <= a; arv <= 1; rre <= 1;
         forever
         begin
            @(negedge clock_i); ta = arv & arr; tr = rv;
            if (tr) ck(rdat === ev && rr === er);
            @(posedge clock_i);
            if (ta) arv <= 0;
            // rready stays high between reads, so a next call re-driving it to 1 in this step is harmless
            if (tr) break;
         end
      end
   endtask
   // result is compared while held, before the random ready lets it go
   task chk(input p, input [19:0] s);
      begin
         @(negedge clock_i);
         while (!dv) @(negedge clock_i);
         ck(dp === p && dsid === s);
         ck(dop === d[63:56] && dun === rsv(d[63:56]));
         ck(dst === (rsv(d[63:56]) ? 8'h10 : 8'h00));
         ck(dca === d[127:64] && dda === d[255:192]);
         ck(dsa === d[191:128] && dsz === d[287:256] && dih === d[319:304]);
         @(posedge clock_i);
      end
   endtask
   always @(posedge clock_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         bad_count = bad_count + 1;
         tally_and_finish;
      end
   end
   initial
   begin
      repeat (3) @(posedge clock_i);
      sys_rst_i <= 0;
      @(posedge clock_i);
      axr(8'h00, 32'h0000_0001, 2'b00);
      axr(8'h20, 32'h0000_0000, 2'b00);
      axr(8'h40, 32'h0000_0000, 2'b10);
      t = $random(seed);
      axw(8'h24, t, 2'b00);
      axr(8'h24, t & 32'h800F_FFFF, 2'b00);
      $display("register test done");
      for (i = 0; i < 256; i = i + 1)
      begin
         for (j = 0; j < 16; j = j + 1) d[32*j +: 32] = $random(seed);
         d[63:56] = i;
         h.send(d, 0);
         chk(d[31], d[19:0]);
      end
      axr(8'h08, 32'h0000_0100, 2'b00);
      axr(8'h0C, 32'h0000_00E1, 2'b00);
      axw(8'h00, 32'h0000_0003, 2'b00);
      axr(8'h0C, 32'h0000_0000, 2'b00);
      $display("opcode test done");
      sh <= 0; q <= 1; d[63:56] = 8'h03;
      h.send(d, 0);
      chk(t[31], t[19:0]);
      sh <= 1; d[63:56] = 8'h01; e = d;
      h.send(d, 0);
      chk(d[31], d[19:0]);
      ib <= 1; d[31:0] = ~d[31:0]; d[63:56] = 8'h04;
      h.send(d, 0);
      chk(e[31], e[19:0]);
      ib <= 0;
      h.send(d, 1);
      chk(1'b0, 20'h0_0A5C);
      $display("identity test done");
      tally_and_finish;
   end
endmodule // tb
